// >>> stall_pkg.sv
/*
 Package for the stepper stall integrator: register offsets, field
 positions, reset values, prescale figures and the bus carrier types.
 Assumes a 32-bit APB with byte addresses and one word per register.
*/
package stall_pkg;
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_COUNT_LOAD = 12'h004;
   localparam logic [11:0] OFF_COUNT_NOW = 12'h008;
   localparam logic [11:0] OFF_ACCUM = 12'h00c;
   localparam logic [11:0] OFF_IRQ_STATUS = 12'h010;
   localparam logic [11:0] OFF_IRQ_ENABLE = 12'h014;
   localparam logic [11:0] OFF_IRQ_CLEAR = 12'h018;
   localparam logic [11:0] OFF_STEP = 12'h01c;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_INTEG = 1;
   localparam int CTRL_TAKEOVER = 2;
   localparam int CTRL_PRESCALE = 3;
   localparam int CTRL_POLARITY = 4;
   localparam int CTRL_BLANK = 5;
   localparam int CTRL_STEP_LO = 6;
   localparam int EV_ZERO = 0;
   localparam int EV_HALF = 1;
   localparam int EV_OVERFLOW = 2;
   localparam int EV_BLANK_DONE = 3;
   localparam int NUM_EVENTS = 4;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] ACCUM_RESET = 16'h0000;
   localparam logic [3:0] IRQ_RESET = 4'h0;
   localparam int PRESCALE_FAST = 64;
   localparam int PRESCALE_SLOW = 512;
   localparam logic [31:0] PSLVERR_NONE = 32'h00000000;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;
   typedef struct packed {
      logic a_plus;
      logic a_minus;
      logic b_plus;
      logic b_minus;
   } coil_t;
endpackage

// >>> tick_divider.sv
/*
 Prescaler for the modulus counter: emits a one-cycle tick every 64 or
 every 512 bus clocks, chosen by a select level. Assumes one clock.
*/
module tick_divider #(
   parameter int FAST_DIV = 64,
   parameter int SLOW_DIV = 512
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Control.
   input wire logic slow_sel,
   // Tick out.
   output logic tick
);
   localparam int CW = $clog2(SLOW_DIV);
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] limit;

   initial begin
      if (FAST_DIV < 2 || SLOW_DIV <= FAST_DIV)
         $error("tick_divider: bad divide ratios");
   end

   assign limit = slow_sel ? CW'(SLOW_DIV - 1) : CW'(FAST_DIV - 1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
         tick <= 1'b0;
      end else if (cnt_r >= limit) begin
         cnt_r <= '0;
         tick <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 1'b1;
         tick <= 1'b0;
      end
   end
endmodule

// >>> stall_integrator.sv
/*
 Stepper stall integrator: APB registers, modulus down-counter,
 blanking, integration with midpoint offset swap, signed accumulator,
 pin takeover and interrupt. Assumes synchronous back-EMF sample pins.
*/
module stall_integrator
   import stall_pkg::*;
#(
   parameter int ACC_W = 16
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire stall_pkg::apb_req_t apb_req,
   output stall_pkg::apb_rsp_t apb_rsp,
   // Back-EMF comparator sample: valid marks a sample, sign is its side.
   input wire logic emf_valid,
   input wire logic emf_negative,
   // Coil pins and shared-pin functions.
   input wire stall_pkg::coil_t other_coil_out,
   output stall_pkg::coil_t coil_out,
   output stall_pkg::coil_t coil_oe_n,
   output logic recirculate,
   output logic takeover,
   output logic offset_swapped,
   // Interrupt.
   output logic irq
);
   import stall_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_COUNT = 2'b01,
      ST_ZERO = 2'b11
   } cnt_state_t;

   logic [7:0] ctrl_r;
   logic [15:0] load_r;
   logic [15:0] count_r;
   logic [15:0] half_r;
   logic [ACC_W-1:0] acc_r;
   logic [NUM_EVENTS-1:0] status_r;
   logic [NUM_EVENTS-1:0] enable_r;
   logic [NUM_EVENTS-1:0] ev;
   logic [NUM_EVENTS-1:0] status_nxt;
   logic [NUM_EVENTS-1:0] enable_nxt;
   logic [1:0] step_r;
   logic swap_armed_r;
   logic swap_r;
   logic blank_mode_r;
   cnt_state_t state_r;
   logic tick;
   logic wr_en;
   logic rd_en;
   logic load_wr;
   logic ctrl_wr;
   logic clr_wr;
   logic integ_on;
   logic sample_pos;
   logic [ACC_W:0] acc_nxt;
   logic zero_hit;

   initial begin
      if (ACC_W != 16)
         $error("stall_integrator: accumulator width must be 16");
   end

   function automatic logic is_wr(input apb_req_t r,
                                  input logic [11:0] off);
      return r.psel && r.penable && r.pwrite && (r.paddr == off);
   endfunction

   assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign rd_en = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
   assign ctrl_wr = is_wr(apb_req, OFF_CTRL);
   assign load_wr = is_wr(apb_req, OFF_COUNT_LOAD);
   assign clr_wr = is_wr(apb_req, OFF_IRQ_CLEAR);
   assign integ_on = ctrl_r[CTRL_INTEG];

   tick_divider #(
      .FAST_DIV(PRESCALE_FAST),
      .SLOW_DIV(PRESCALE_SLOW)
   ) u_div (
      .pclk(pclk),
      .presetn(presetn),
      .slow_sel(ctrl_r[CTRL_PRESCALE]),
      .tick(tick)
   );

   // Control, load and enable registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= CTRL_RESET;
         load_r <= COUNT_RESET;
         enable_r <= IRQ_RESET;
         step_r <= 2'h0;
      end else begin
         if (ctrl_wr)
            ctrl_r <= apb_req.pwdata[7:0];
         if (load_wr)
            load_r <= apb_req.pwdata[15:0];
         if (is_wr(apb_req, OFF_IRQ_ENABLE))
            enable_r <= apb_req.pwdata[NUM_EVENTS-1:0];
         if (is_wr(apb_req, OFF_STEP))
            step_r <= apb_req.pwdata[1:0];
      end
   end

   // Counter runs only while the run bit is set; a load restarts it.
   assign zero_hit = (state_r == ST_COUNT) && tick && (count_r == 16'h0001);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_IDLE;
         count_r <= COUNT_RESET;
         half_r <= COUNT_RESET;
         blank_mode_r <= 1'b0;
      end else if (!ctrl_r[CTRL_RUN]) begin
         state_r <= ST_IDLE;
         count_r <= COUNT_RESET;
      end else if (load_wr) begin
         count_r <= apb_req.pwdata[15:0];
         half_r <= {1'b0, apb_req.pwdata[15:1]};
         blank_mode_r <= ctrl_r[CTRL_BLANK];
         state_r <= (apb_req.pwdata[15:0] == 16'h0000) ? ST_ZERO : ST_COUNT;
      end else begin
         case (state_r)
            ST_COUNT: begin
               if (tick) begin
                  count_r <= count_r - 16'h0001;
                  if (count_r == 16'h0001)
                     state_r <= ST_ZERO;
               end
            end
            ST_ZERO: count_r <= COUNT_RESET;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Swap arms only if integrate comes after run and load.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         swap_armed_r <= 1'b0;
         swap_r <= 1'b0;
      end else if (ctrl_wr && apb_req.pwdata[CTRL_INTEG] && !integ_on) begin
         swap_armed_r <= ctrl_r[CTRL_RUN] && (state_r == ST_COUNT);
         swap_r <= 1'b0;
      end else if (!integ_on) begin
         swap_armed_r <= 1'b0;
         swap_r <= 1'b0;
      end else if (swap_armed_r && tick && state_r == ST_COUNT &&
                   count_r == half_r + 16'h0001) begin
         swap_r <= 1'b1;
         swap_armed_r <= 1'b0;
      end
   end

   // Polarity bit and offset swap each invert the sample side.
   assign sample_pos = emf_negative ^ ctrl_r[CTRL_POLARITY] ^ swap_r ^ 1'b1;
   assign acc_nxt = sample_pos ? {acc_r[ACC_W-1], acc_r} + 17'h00001
                               : {acc_r[ACC_W-1], acc_r} - 17'h00001;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_r <= ACCUM_RESET;
      end else if (load_wr && apb_req.pwdata[31]) begin
         acc_r <= ACCUM_RESET;
      end else if (integ_on && emf_valid && state_r == ST_COUNT &&
                   acc_nxt[ACC_W] == acc_nxt[ACC_W-1]) begin
         acc_r <= acc_nxt[ACC_W-1:0];
      end
   end

   // Events; a set in the same cycle as a clear wins.
   always_comb begin
      ev = '0;
      ev[EV_ZERO] = zero_hit;
      ev[EV_HALF] = swap_armed_r && tick && state_r == ST_COUNT &&
                    count_r == half_r + 16'h0001;
      ev[EV_OVERFLOW] = integ_on && emf_valid && state_r == ST_COUNT &&
                        acc_nxt[ACC_W] != acc_nxt[ACC_W-1];
      ev[EV_BLANK_DONE] = zero_hit && blank_mode_r;
   end

   // The pin follows next status and next enable together, so a write to
   // the enable register cannot leave the pin one cycle out of step.
   assign status_nxt = (status_r & ~(clr_wr ? apb_req.pwdata[NUM_EVENTS-1:0]
                                            : 4'h0)) | ev;
   assign enable_nxt = is_wr(apb_req, OFF_IRQ_ENABLE) ?
                       apb_req.pwdata[NUM_EVENTS-1:0] : enable_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_r <= IRQ_RESET;
         irq <= 1'b0;
      end else begin
         status_r <= status_nxt;
         irq <= |(status_nxt & enable_nxt);
      end
   end

   // Pins: in takeover the unit drives the coils, coil A released while integrating or blanking, else other functions.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         coil_out <= '0;
         coil_oe_n <= '1;
         recirculate <= 1'b0;
         takeover <= 1'b0;
         offset_swapped <= 1'b0;
      end else begin
         takeover <= ctrl_r[CTRL_TAKEOVER];
         offset_swapped <= swap_r;
         recirculate <= ctrl_r[CTRL_TAKEOVER] && blank_mode_r &&
                        state_r == ST_COUNT;
         if (ctrl_r[CTRL_TAKEOVER]) begin
            coil_out <= {step_r[1], ~step_r[1], step_r[0], ~step_r[0]};
            coil_oe_n <= '0;
            if (integ_on || (blank_mode_r && state_r == ST_COUNT))
               coil_oe_n <= {2'b11, 2'b00};
         end else begin
            coil_out <= other_coil_out;
            coil_oe_n <= '0;
         end
      end
   end

   // APB read data is registered in the setup cycle, so reads see the
   // live accumulator without stalling integration.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         apb_rsp <= '0;
      end else begin
         apb_rsp.pready <= apb_req.psel && !apb_req.penable;
         apb_rsp.pslverr <= 1'b0;
         if (rd_en) begin
            case (apb_req.paddr)
               OFF_CTRL: apb_rsp.prdata <= {24'h000000, ctrl_r};
               OFF_COUNT_LOAD: apb_rsp.prdata <= {16'h0000, load_r};
               OFF_COUNT_NOW: apb_rsp.prdata <= {16'h0000, count_r};
               OFF_ACCUM: apb_rsp.prdata <= {16'h0000, acc_r};
               OFF_IRQ_STATUS: apb_rsp.prdata <= {28'h0000000, status_r};
               OFF_IRQ_ENABLE: apb_rsp.prdata <= {28'h0000000, enable_r};
               OFF_STEP: apb_rsp.prdata <= {30'h00000000, step_r};
               default: apb_rsp.prdata <= PSLVERR_NONE;
            endcase
         end else if (wr_en) begin
            apb_rsp.prdata <= 32'h00000000;
         end
      end
   end

   AST_ZERO_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
      zero_hit |=> status_r[EV_ZERO])
      else $error("zero event not flagged");
   AST_COUNT_DOWN: assert property (@(posedge pclk) disable iff (!presetn)
      (state_r == ST_COUNT && tick && ctrl_r[CTRL_RUN] && !load_wr)
      |=> count_r == $past(count_r) - 16'h0001)
      else $error("counter did not step down");
   AST_HOLD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      (state_r == ST_ZERO && !load_wr) |=> count_r == 16'h0000)
      else $error("counter left zero");
   AST_NO_SWAP: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_wr && apb_req.pwdata[CTRL_INTEG] && !integ_on &&
       state_r != ST_COUNT) |=> !swap_armed_r)
      else $error("swap armed out of order");
   AST_SWAP_ONCE: assert property (@(posedge pclk) disable iff (!presetn)
      (swap_r && integ_on) |=> !swap_armed_r)
      else $error("swap rearmed");
   AST_ACC_STEP: assert property (@(posedge pclk) disable iff (!presetn)
      (integ_on && emf_valid && state_r == ST_COUNT && !ev[EV_OVERFLOW] &&
       !load_wr) |=> acc_r != $past(acc_r))
      else $error("accumulator did not move");
   AST_OVF: assert property (@(posedge pclk) disable iff (!presetn)
      ev[EV_OVERFLOW] |=> status_r[EV_OVERFLOW] && acc_r == $past(acc_r))
      else $error("overflow mishandled");
   AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 irq == |(status_r & enable_r))
      else $error("irq does not match status");
   AST_TAKEOVER: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_r[CTRL_TAKEOVER] |=> takeover)
      else $error("pins not taken over");
   AST_TICK: assert property (@(posedge pclk) disable iff (!presetn)
      tick |=> !tick [*8])
      else $error("tick too frequent");
   COV_ZERO: cover property (@(posedge pclk) disable iff (!presetn) zero_hit);
   COV_SWAP: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(swap_r));
   COV_OVF: cover property (@(posedge pclk) disable iff (!presetn)
      ev[EV_OVERFLOW]);
   COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule

// >>> emf_source.sv
/*
 Back-EMF sample source standing in for the undriven coil.
 Assumes the bench raises go for exactly as many cycles as samples wanted.
*/
module emf_source (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Command from the bench.
   input wire logic go,
   input wire logic neg,
   // Sample out.
   output logic emf_valid,
   output logic emf_negative
);
   timeunit 1ns;
   timeprecision 1ns;
   // The sign line toggles between samples so a stale level is never kept.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         emf_valid <= 1'b0;
         emf_negative <= 1'b0;
      end else begin
         emf_valid <= go;
         emf_negative <= go ? neg : ~emf_negative;
      end
   end
endmodule

// >>> stepper_stall_integrator_tb.sv
/*
 Self-checking bench for the stall integrator: APB master tasks, one
 task per scenario. Assumes the package offsets; the master waits for pready.
*/
module stepper_stall_integrator_tb;
   import stall_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   apb_req_t req = '0;
   apb_rsp_t rsp;
   logic go = 1'b0;
   logic neg = 1'b0;
   logic emf_valid;
   logic emf_negative;
   coil_t coil_out;
   coil_t coil_oe_n;
   logic recirculate;
   logic takeover;
   logic offset_swapped;
   logic irq;
   logic [31:0] rd;
   logic err;
   int n_fail = 0;
   int n_checks = 0;

   always #25 pclk = ~pclk;

   emf_source coil (.pclk(pclk), .presetn(presetn), .go(go), .neg(neg),
      .emf_valid(emf_valid), .emf_negative(emf_negative));

   stall_integrator dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
      .apb_rsp(rsp), .emf_valid(emf_valid), .emf_negative(emf_negative),
      .other_coil_out(coil_t'(4'ha)), .coil_out(coil_out),
      .coil_oe_n(coil_oe_n), .recirculate(recirculate),
      .takeover(takeover), .offset_swapped(offset_swapped), .irq(irq));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge pclk);
      req.penable <= 1'b1;
      do @(posedge pclk); while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      // One idle edge keeps the next setup from reassigning psel at once.
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
      chk(err, 32'h0);
   endtask

   task automatic burst(input int n, input logic s);
      neg <= s;
      go <= 1'b1;
      repeat (n) @(posedge pclk);
      go <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask

   task automatic wait_irq(output int c);
      c = 0;
      while (irq !== 1'b1 && c < 2000) begin
         @(posedge pclk);
         c++;
      end
   endtask

   task automatic t_reset;
      chk(coil_oe_n, 32'hf);
      chk(irq, 32'h0);
      rdchk(OFF_CTRL, 32'h0);
      rdchk(OFF_COUNT_NOW, 32'h0);
      rdchk(OFF_ACCUM, 32'h0);
      rdchk(OFF_IRQ_STATUS, 32'h0);
      rdchk(OFF_IRQ_ENABLE, 32'h0);
      rdchk(OFF_IRQ_CLEAR, 32'h0);
      rdchk(12'h020, 32'h0);
      $display("test reset done");
   endtask

   task automatic t_offset;
      int n;
      wr(OFF_IRQ_ENABLE, 32'h1);
      wr(OFF_CTRL, 32'h01);
      wr(OFF_COUNT_LOAD, 32'h80000008);
      wr(OFF_CTRL, 32'h03);
      burst(10, 1'b0);
      rdchk(OFF_ACCUM, 32'h000a);
      burst(4, 1'b1);
      rdchk(OFF_ACCUM, 32'h0006);
      wait_irq(n);
      chk(irq, 32'h1);
      chk(offset_swapped, 32'h1);
      rdchk(OFF_IRQ_STATUS, 32'h3);
      rdchk(OFF_COUNT_NOW, 32'h0);
      wr(OFF_CTRL, 32'h01);
      rdchk(OFF_ACCUM, 32'h0006);
      // A result above the bench's stall ceiling means the step completed.
      chk(rd[15:0] > 16'h0002, 32'h1);
      wr(OFF_IRQ_CLEAR, 32'hf);
      @(posedge pclk);
      chk(irq, 32'h0);
      $display("test offset done");
   endtask

   task automatic t_reverse;
      int n;
      wr(OFF_CTRL, 32'h12);
      wr(OFF_CTRL, 32'h13);
      wr(OFF_COUNT_LOAD, 32'h80000004);
      burst(5, 1'b0);
      rdchk(OFF_ACCUM, 32'hfffb);
      wait_irq(n);
      chk(offset_swapped, 32'h0);
      rdchk(OFF_IRQ_STATUS, 32'h1);
      wr(OFF_CTRL, 32'h0);
      wr(OFF_IRQ_CLEAR, 32'hf);
      $display("test reverse done");
   endtask

   task automatic t_timing(input logic [31:0] c, input int lo, input int hi);
      int n;
      wr(OFF_IRQ_ENABLE, 32'h1);
      wr(OFF_CTRL, c);
      wr(OFF_COUNT_LOAD, 32'h2);
      wait_irq(n);
      chk(n >= lo && n <= hi, 32'h1);
      rdchk(OFF_COUNT_NOW, 32'h0);
      wr(OFF_CTRL, 32'h0);
      wr(OFF_IRQ_CLEAR, 32'hf);
      $display("test timing done");
   endtask

   task automatic t_blank;
      int n;
      wr(OFF_IRQ_ENABLE, 32'h8);
      wr(OFF_CTRL, 32'h25);
      wr(OFF_COUNT_LOAD, 32'h2);
      @(posedge pclk);
      chk(recirculate, 32'h1);
      chk(coil_oe_n, 32'hc);
      wait_irq(n);
      apb(1'b0, OFF_IRQ_STATUS, 32'h0);
      chk(rd & 32'h8, 32'h8);
      chk(recirculate, 32'h0);
      wr(OFF_CTRL, 32'h0);
      wr(OFF_IRQ_CLEAR, 32'hf);
      $display("test blank done");
   endtask

   task automatic t_takeover;
      wr(OFF_STEP, 32'h1);
      wr(OFF_CTRL, 32'h04);
      @(posedge pclk);
      chk(takeover, 32'h1);
      chk(coil_oe_n, 32'h0);
      chk(coil_out, 32'h6);
      wr(OFF_CTRL, 32'h0);
      @(posedge pclk);
      chk(takeover, 32'h0);
      chk(coil_oe_n, 32'h0);
      chk(coil_out, 32'ha);
      $display("test takeover done");
   endtask

   // Integrate goes on before run and load, so no midpoint swap turns the
   // count back down; the slow window outlasts the full positive range.
   task automatic t_overflow;
      wr(OFF_IRQ_ENABLE, 32'h0);
      wr(OFF_CTRL, 32'h0a);
      wr(OFF_CTRL, 32'h0b);
      wr(OFF_COUNT_LOAD, 32'h80000064);
      burst(32800, 1'b0);
      rdchk(OFF_IRQ_STATUS, 32'h4);
      rdchk(OFF_ACCUM, 32'h7fff);
      chk(irq, 32'h0);
      wr(OFF_IRQ_ENABLE, 32'h4);
      @(posedge pclk);
      chk(irq, 32'h1);
      wr(OFF_CTRL, 32'h0);
      wr(OFF_IRQ_CLEAR, 32'hf);
      @(posedge pclk);
      chk(irq, 32'h0);
      $display("test overflow done");
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      #(60000 * 50);
      n_fail++;
      close_out();
   end

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_offset();
      t_reverse();
      t_timing(32'h01, 60, 140);
      t_timing(32'h09, 508, 1040);
      t_blank();
      t_takeover();
      t_overflow();
      close_out();
   end
endmodule
